// [mrr_acc_if.sv]
// carrier between bank and one accumulator lane
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface mrr_acc_if;
  import mrr_pkg::*;
  logic        clear;
  logic        add;
  logic        res11;
  mrr_sample_t sample;
  mrr_sum_t    sum;
  modport bank (output clear, output add, output res11, output sample,
                input sum);
  modport lane (input clear, input add, input res11, input sample,
                output sum);
endinterface : mrr_acc_if
`default_nettype wire

// [mrr_acc_lane.sv]
// one 25-bit accumulator lane in 14-bit count units
// assumes samples arrive synchronous to clk, one per add pulse
`timescale 1ns/1ps
`default_nettype none
`include "mrr_defines.svh"
module mrr_acc_lane
  import mrr_pkg::*;
(
  input  wire logic clk,   // 20 MHz clock
  input  wire logic rst_n, // sync reset, low
  mrr_acc_if.lane   acc    // lane controls and sum
);
  typedef struct packed {
    mrr_sum_t sum;
  } mrr_lane_s;
  mrr_lane_s cur;
  mrr_lane_s next_cur;
  mrr_sum_t  addend;

  always_comb begin
    next_cur = cur;
    // 11-bit codes sit in the top of the 14-bit range
    if (acc.res11) begin
      addend = {14'h0000, acc.sample[10:0]} << `MRR_SHIFT_11BIT;
    end else begin
      addend = {11'h000, acc.sample};
    end
    if (acc.clear) begin
      next_cur.sum = '0;
    end else if (acc.add) begin
      next_cur.sum = cur.sum + addend;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign acc.sum = cur.sum;

  low_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (acc.res11 && acc.add && !acc.clear && cur.sum[2:0] == 3'h0)
      |=> cur.sum[2:0] == 3'h0)
    else $error("11-bit sum low bits populated");
  sum_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (acc.add && !acc.clear && !acc.res11)
      |=> cur.sum == $past(cur.sum) + {11'h000, $past(acc.sample)})
    else $error("14-bit sum step wrong");
endmodule : mrr_acc_lane
`default_nettype wire

// [mrr_defines.svh]
// offsets, field positions and reset values of the result bank
// assumes inclusion by bare name from package or modules
`ifndef MRR_DEFINES_SVH
`define MRR_DEFINES_SVH
`define MRR_BUS_RESULT_HI  8'h10
`define MRR_BUS_RESULT_LO  8'h11
`define MRR_SENSE_RESULT_HI 8'h12
`define MRR_SENSE_RESULT_LO 8'h13
`define MRR_BUS_ACC_B3     8'h14
`define MRR_BUS_ACC_B0     8'h17
`define MRR_CUR_ACC_B3     8'h18
`define MRR_CUR_ACC_B0     8'h1B
`define MRR_RESULT_LSB     6
`define MRR_ACC_LSB        7
`define MRR_SHIFT_11BIT    3
`define MRR_RESET_VALUE    32'h0000_0000
`endif

// [mrr_host.sv]
// host model: byte reads and writes on the bank's register port
// assumes bank samples strobes at posedge, answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module mrr_host (
  input  wire logic       clk,       // bank clock
  output logic      [7:0] reg_addr,  // byte address
  output logic            reg_rd,    // read strobe
  output logic            reg_wr,    // write strobe
  output logic      [7:0] reg_wdata, // write data
  input  wire logic [7:0] reg_rdata  // read data
);
  initial begin
    {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
  end
  // reads go to any address in any phase; the task does not wait for the Read state
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    // released address must not keep showing the old value
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
endmodule : mrr_host
`default_nettype wire

// [mrr_pkg.sv]
// types of the measurement result bank
// assumes mrr_defines.svh on the include path
package mrr_pkg;
  typedef logic [9:0]  mrr_avg_t;
  typedef logic [24:0] mrr_sum_t;
  typedef logic [13:0] mrr_sample_t;
  typedef enum logic [1:0] {
    MRR_IDLE = 2'b01,
    MRR_READ = 2'b10
  } mrr_phase_e;
  typedef struct packed {
    mrr_avg_t   bus_avg_value;
    mrr_avg_t   sense_avg_value;
    mrr_sum_t   bus_sum_value;
    mrr_sum_t   current_sum_value;
    mrr_phase_e phase;
    logic [7:0] rdata;
  } mrr_state_s;
endpackage : mrr_pkg

// [mrr_result_bank.sv]
// read-only result and accumulator bank, byte-addressed
// assumes a serial management front end giving byte address and strobes
// and a measurement engine driving the update port, all on clk
`timescale 1ns/1ps
`default_nettype none
`include "mrr_defines.svh"
module mrr_result_bank
  import mrr_pkg::*;
(
  input  wire logic        clk,          // 20 MHz clock
  input  wire logic        rst_n,        // sync reset, low
  input  wire logic [7:0]  reg_addr,     // byte address
  input  wire logic        reg_rd,       // read strobe
  input  wire logic        reg_wr,       // write strobe, ignored
  input  wire logic [7:0]  reg_wdata,    // write data, ignored
  output logic      [7:0]  reg_rdata,    // read data, registered
  output logic             reg_hit,      // address maps here
  input  wire logic        int_start,    // integration begins
  input  wire logic        int_end,      // integration ends, Read state
  input  wire logic        res11,        // 11-bit resolution
  input  wire logic        rail_smp,     // rail sample valid
  input  wire mrr_sample_t rail_voltage, // rail sample
  input  wire logic        shunt_smp,    // shunt sample valid
  input  wire mrr_sample_t shunt_voltage,// shunt sample
  input  wire logic        avg_load,     // load new averages
  input  wire mrr_avg_t    bus_avg_in,   // new rail average
  input  wire mrr_avg_t    sense_avg_in, // new shunt average
  output logic             sums_valid    // Read state, sums valid
);
  mrr_state_s cur;
  mrr_state_s next_cur;
  logic [31:0] bus_word;
  logic [31:0] cur_word;
  logic [15:0] bus_res;
  logic [15:0] sense_res;
  logic        in_read;

  mrr_acc_if bus_acc ();
  mrr_acc_if cur_acc ();

  // sums are only frozen and meaningful once integration ended
  assign in_read = (cur.phase == MRR_READ);

  assign bus_acc.clear  = int_start;
  assign bus_acc.add    = rail_smp && !in_read;
  assign bus_acc.res11  = res11;
  assign bus_acc.sample = rail_voltage;
  assign cur_acc.clear  = int_start;
  assign cur_acc.add    = shunt_smp && !in_read;
  assign cur_acc.res11  = res11;
  assign cur_acc.sample = shunt_voltage;

  mrr_acc_lane u_bus_lane (
    .clk   (clk),
    .rst_n (rst_n),
    .acc   (bus_acc)
  );
  mrr_acc_lane u_cur_lane (
    .clk   (clk),
    .rst_n (rst_n),
    .acc   (cur_acc)
  );

  assign bus_res   = {cur.bus_avg_value, 6'h00};
  assign sense_res = {cur.sense_avg_value, 6'h00};
  assign bus_word  = {cur.bus_sum_value, 7'h00};
  assign cur_word  = {cur.current_sum_value, 7'h00};

  always_comb begin
    next_cur = cur;
    next_cur.bus_sum_value     = bus_acc.sum;
    next_cur.current_sum_value = cur_acc.sum;
    if (int_start) begin
      next_cur.phase = MRR_IDLE;
    end else if (int_end) begin
      next_cur.phase = MRR_READ;
    end
    if (avg_load) begin
      next_cur.bus_avg_value   = bus_avg_in;
      next_cur.sense_avg_value = sense_avg_in;
    end
    // writes never reach the state; reads only pick a byte
    if (reg_rd) begin
      unique case (reg_addr)
        `MRR_BUS_RESULT_HI:   next_cur.rdata = bus_res[15:8];
        `MRR_BUS_RESULT_LO:   next_cur.rdata = bus_res[7:0];
        `MRR_SENSE_RESULT_HI: next_cur.rdata = sense_res[15:8];
        `MRR_SENSE_RESULT_LO: next_cur.rdata = sense_res[7:0];
        8'h14:                next_cur.rdata = bus_word[31:24];
        8'h15:                next_cur.rdata = bus_word[23:16];
        8'h16:                next_cur.rdata = bus_word[15:8];
        `MRR_BUS_ACC_B0:      next_cur.rdata = bus_word[7:0];
        8'h18:                next_cur.rdata = cur_word[31:24];
        8'h19:                next_cur.rdata = cur_word[23:16];
        8'h1A:                next_cur.rdata = cur_word[15:8];
        `MRR_CUR_ACC_B0:      next_cur.rdata = cur_word[7:0];
        default:              next_cur.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur       <= '0;
      cur.phase <= MRR_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata  = cur.rdata;
  assign reg_hit    = (reg_addr >= `MRR_BUS_RESULT_HI) &&
                      (reg_addr <= `MRR_CUR_ACC_B0);
  assign sums_valid = in_read;

  bus_hi_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h10)
      |=> reg_rdata == $past(cur.bus_avg_value[9:2]))
    else $error("bus result high byte wrong");
  sense_lo_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h13)
      |=> reg_rdata == {$past(cur.sense_avg_value[1:0]), 6'h00})
    else $error("sense result low byte wrong");
  result_lsb_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_addr == 8'h11 || reg_addr == 8'h13))
      |=> reg_rdata[5:0] == 6'h00)
    else $error("result low bits not zero");
  bus_acc_top_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h14)
      |=> reg_rdata == $past(cur.bus_sum_value[24:17]))
    else $error("bus sum top byte wrong");
  cur_acc_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h1A)
      |=> reg_rdata == $past(cur.current_sum_value[8:1]))
    else $error("current sum byte wrong");
  acc_lsb_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_addr == 8'h17 || reg_addr == 8'h1B))
      |=> reg_rdata[6:0] == 7'h00)
    else $error("sum low bits not zero");
  read_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_read && !int_start) [*2]
      |-> $stable(cur.bus_sum_value))
    else $error("sum moved in Read state");
  write_noeffect_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && !avg_load)
      |=> $stable(cur.bus_avg_value) && $stable(cur.sense_avg_value))
    else $error("write changed a result");
endmodule : mrr_result_bank
`default_nettype wire

// [mrr_result_bank_bench.sv]
// self-checking bench of the result bank with a host model
// assumes all bench stimulus lands on falling edges
`timescale 1ns/1ps
`default_nettype none
module mrr_result_bank_bench;
  import mrr_pkg::*;
  logic        clk, rst_n, int_start, int_end, res11;
  logic        rail_smp, shunt_smp, avg_load, reg_rd, reg_wr;
  logic        reg_hit, sums_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  mrr_sample_t rail_voltage, shunt_voltage;
  mrr_avg_t    bus_avg_in, sense_avg_in;
  int          fails, comparisons;

  mrr_result_bank dut (.clk, .rst_n, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .reg_hit, .int_start, .int_end, .res11,
    .rail_smp, .rail_voltage, .shunt_smp, .shunt_voltage, .avg_load,
    .bus_avg_in, .sense_avg_in, .sums_valid);
  mrr_host host (.clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata);

  always #25 clk = ~clk;

  task automatic final_report;
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("byte %h", a), 32'(e), 32'(d));
  endtask : rdc
  task automatic rd16(input logic [7:0] a, input mrr_avg_t v);
    logic [15:0] w;
    w = {v, 6'h00};
    rdc(a, w[15:8]);
    rdc(a + 8'h01, w[7:0]);
  endtask : rd16
  task automatic rd32(input logic [7:0] a, input mrr_sum_t s);
    logic [31:0] w;
    w = {s, 7'h00};
    for (int i = 0; i < 4; i++) rdc(a + 8'(i), w[31-8*i -: 8]);
  endtask : rd32
  task automatic ctl(input logic st, input logic en);
    int_start = st;
    int_end = en;
    @(negedge clk);
    {int_start, int_end} = 2'b00;
  endtask : ctl
  task automatic smp(input mrr_sample_t r, input mrr_sample_t s);
    rail_voltage = r;
    shunt_voltage = s;
    {rail_smp, shunt_smp} = 2'b11;
    @(negedge clk);
    {rail_smp, shunt_smp} = 2'b00;
  endtask : smp

  task automatic t_reset;
    for (int a = 16; a < 28; a++) rdc(8'(a), 8'h00);
    chk("sums_valid", 0, 32'(sums_valid));
    rdc(8'hE4, 8'h00);
    chk("hit 1B", 1, 32'(reg_hit));
    rdc(8'hE3, 8'h00);
    chk("hit 1C", 0, 32'(reg_hit));
  endtask : t_reset
  task automatic t_avg;
    bus_avg_in = 10'h2B5;
    sense_avg_in = 10'h1CA;
    avg_load = 1'b1;
    @(negedge clk);
    avg_load = 1'b0;
    {bus_avg_in, sense_avg_in} = '1;
    host.wr(8'h10, 8'h00);
    host.wr(8'h13, 8'hFF);
    rd16(8'h10, 10'h2B5);
    rd16(8'h12, 10'h1CA);
  endtask : t_avg
  task automatic t_sum(input logic m, input mrr_sum_t eb,
                       input mrr_sum_t ec);
    res11 = m;
    ctl(1'b1, 1'b0);
    smp(14'h3FFF, 14'h3805);
    chk("sums_valid", 0, 32'(sums_valid));
    smp(14'h07FF, 14'h0ABC);
    @(negedge clk);
    ctl(1'b0, 1'b1);
    // samples in the Read state must not disturb the frozen sums
    smp(14'h1111, 14'h1111);
    chk("sums_valid", 1, 32'(sums_valid));
    rd32(8'h14, eb);
    rd32(8'h18, ec);
  endtask : t_sum

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {int_start, int_end, res11, rail_smp, shunt_smp, avg_load} = '0;
    {rail_voltage, shunt_voltage, bus_avg_in, sense_avg_in} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_avg();
    t_sum(1'b0, 25'h0047FE, 25'h0042C1);
    t_sum(1'b1, 25'h007FF0, 25'h001608);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : mrr_result_bank_bench
`default_nettype wire
